/* File: esr_fifo.sv */
`default_nettype none
module esr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = esr_pkg::FIFO_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : gen_bad_size
    $error("fifo depth must be a power of two of at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic [PW:0]      next_wr_ptr;
  logic [PW:0]      next_rd_ptr;

  assign in_ready  = !((wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[PW-1:0]];

  // ****************************************
  // Pointers
  // ****************************************
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (flush) begin
      next_rd_ptr = wr_ptr;
    end else begin
      if (in_valid && in_ready) begin
        next_wr_ptr = wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        next_rd_ptr = rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage
  always_ff @(posedge clk_sys) begin
    if (in_valid && in_ready && !flush) begin
      mem[wr_ptr[PW-1:0]] <= in_data;
    end
  end

endmodule
`default_nettype wire

/* File: esr_master_model.sv */
`default_nettype none
module esr_master_model (
  // Clock
  input  wire logic clk_sys,
  // Bus lines
  output logic      scl,
  output logic      m_oe,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Two-wire controller, 800 ns clock
  // ****************************************
  initial begin
    scl  = 1'h1;
    m_oe = 1'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Start, also a repeated start from a low clock
  task automatic start_cond();
    m_oe = 1'h0;
    tick(4);
    scl = 1'h1;
    tick(2);
    m_oe = 1'h1;
    tick(2);
    scl = 1'h0;
    tick(2);
  endtask

  // Stop after a low clock
  task automatic stop_cond();
    m_oe = 1'h1;
    tick(4);
    scl = 1'h1;
    tick(2);
    m_oe = 1'h0;
    tick(4);
  endtask

  // Nine clocks, MSB first; a one bit leaves the wire to the pull-up
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      tick(1);
      m_oe = ~tx[i];
      tick(3);
      scl = 1'h1;
      tick(3);
      rx[i] = sda;
      tick(1);
      scl = 1'h0;
    end
  endtask
endmodule
`default_nettype wire

/* File: esr_pkg.sv */
`default_nettype none
package esr_pkg;

  // ****************************************
  // Constants
  // ****************************************
  localparam int          ADDR_W_DEF     = 15;
  localparam int          FIFO_DEPTH_DEF = 16;
  localparam logic [3:0]  DEV_TYPE       = 4'hA;
  localparam logic [2:0]  BIT_LAST       = 3'h7;
  localparam logic [2:0]  BIT_RST        = 3'h0;
  localparam logic [7:0]  FILL_BYTE      = 8'hFF;
  localparam logic [7:0]  BYTE_RST       = 8'h00;
  localparam logic [15:0] ADDR_RST       = 16'h0000;
  localparam logic [1:0]  LINE_IDLE      = 2'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_DEV     = 3'b001,
    ST_ACK_OUT = 3'b010,
    ST_ADDR_HI = 3'b011,
    ST_ADDR_LO = 3'b100,
    ST_TX      = 3'b101,
    ST_ACK_IN  = 3'b110,
    ST_IGNORE  = 3'b111
  } esr_state_type;

  typedef enum logic [1:0] {
    AF_READ = 2'b00,
    AF_HI   = 2'b01,
    AF_LO   = 2'b10,
    AF_DONE = 2'b11
  } esr_after_type;

  typedef struct packed {
    logic        scl;
    logic        sda;
  } esr_line_type;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
  } esr_rd_req_type;

  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } esr_rd_rsp_type;

endpackage
`default_nettype wire

/* File: esr_seq_read.sv */
`default_nettype none
module esr_seq_read #(
  parameter int ADDR_W     = esr_pkg::ADDR_W_DEF,
  parameter int FIFO_DEPTH = esr_pkg::FIFO_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // Address select straps
  input  wire logic                   addr_select_low,
  input  wire logic                   addr_select_high,
  // Two-wire bus pins
  input  wire esr_pkg::esr_line_type  line_in,
  output logic                        sda_o,
  output logic                        sda_oe,
  // Array read port
  output esr_pkg::esr_rd_req_type     rd_req,
  input  wire esr_pkg::esr_rd_rsp_type rd_rsp
);

  if (ADDR_W < 8 || ADDR_W > 16) begin : gen_bad_width
    $error("address width must lie between 8 and 16");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [1:0] line_d;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // Idle bus level, so no false clock edge follows reset
      sync1  <= {2'h0, esr_pkg::LINE_IDLE};
      sync2  <= {2'h0, esr_pkg::LINE_IDLE};
      line_d <= esr_pkg::LINE_IDLE;
    end else begin
      sync1  <= {addr_select_high, addr_select_low, line_in.scl, line_in.sda};
      sync2  <= sync1;
      line_d <= sync2[1:0];
    end
  end

  assign scl_s     = sync2[1];
  assign sda_s     = sync2[0];
  assign scl_rise  = scl_s && !line_d[1];
  assign scl_fall  = !scl_s && line_d[1];
  assign start_det = scl_s && line_d[1] && line_d[0] && !sda_s;
  assign stop_det  = scl_s && line_d[1] && !line_d[0] && sda_s;

  // ****************************************
  // Prefetch buffer
  // ****************************************
  logic       push;
  logic       pop;
  logic       flush;
  logic       fifo_in_ready;
  logic       fifo_valid;
  logic [7:0] fifo_data;

  esr_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .flush     (flush),
    .in_valid  (push),
    .in_data   (rd_rsp.data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (pop)
  );

  // ****************************************
  // Bus protocol
  // ****************************************
  esr_pkg::esr_state_type state;
  esr_pkg::esr_state_type next_state;
  esr_pkg::esr_after_type after;
  esr_pkg::esr_after_type next_after;
  logic [2:0]             bit_cnt;
  logic [2:0]             next_bit_cnt;
  logic [7:0]             shreg;
  logic [7:0]             next_shreg;
  logic [7:0]             addr_hi;
  logic [7:0]             next_addr_hi;
  logic                   byte_full;
  logic                   next_byte_full;
  logic                   ack_seen;
  logic                   next_ack_seen;
  logic                   next_sda_oe;
  logic [ADDR_W-1:0]      addr_cnt;
  logic [ADDR_W-1:0]      next_addr_cnt;
  logic                   tx_load;

  always_comb begin
    next_state     = state;
    next_after     = after;
    next_bit_cnt   = bit_cnt;
    next_shreg     = shreg;
    next_addr_hi   = addr_hi;
    next_byte_full = byte_full;
    next_ack_seen  = ack_seen;
    next_sda_oe    = sda_oe;
    next_addr_cnt  = addr_cnt;
    tx_load        = 1'b0;
    flush          = 1'b0;
    unique case (state)
      esr_pkg::ST_IDLE, esr_pkg::ST_IGNORE: begin
      end
      esr_pkg::ST_DEV, esr_pkg::ST_ADDR_HI, esr_pkg::ST_ADDR_LO: begin
        if (scl_rise) begin
          next_shreg     = {shreg[6:0], sda_s};
          next_bit_cnt   = bit_cnt + 1'b1;
          next_byte_full = (bit_cnt == esr_pkg::BIT_LAST);
        end else if (scl_fall && byte_full) begin
          next_byte_full = 1'b0;
          next_sda_oe    = 1'b1;
          next_state     = esr_pkg::ST_ACK_OUT;
          if (state == esr_pkg::ST_DEV) begin
            // Type code, strap match and direction bit
            if (shreg[7:4] == esr_pkg::DEV_TYPE && shreg[3:2] == sync2[3:2]) begin
              next_after = shreg[0] ? esr_pkg::AF_READ : esr_pkg::AF_HI;
            end else begin
              next_sda_oe = 1'b0;
              next_state  = esr_pkg::ST_IGNORE;
            end
          end else if (state == esr_pkg::ST_ADDR_HI) begin
            next_addr_hi = shreg;
            next_after   = esr_pkg::AF_LO;
          end else begin
            // Word address loads the counter and restarts prefetch
            next_addr_cnt = ADDR_W'({addr_hi, shreg});
            flush         = 1'b1;
            next_after    = esr_pkg::AF_DONE;
          end
        end
      end
      esr_pkg::ST_ACK_OUT: begin
        if (scl_fall) begin
          next_sda_oe  = 1'b0;
          next_bit_cnt = esr_pkg::BIT_RST;
          unique case (after)
            esr_pkg::AF_READ: tx_load = 1'b1;
            esr_pkg::AF_HI:   next_state = esr_pkg::ST_ADDR_HI;
            esr_pkg::AF_LO:   next_state = esr_pkg::ST_ADDR_LO;
            esr_pkg::AF_DONE: next_state = esr_pkg::ST_IGNORE;
          endcase
        end
      end
      esr_pkg::ST_TX: begin
        if (scl_fall) begin
          if (bit_cnt == esr_pkg::BIT_LAST) begin
            next_sda_oe = 1'b0;
            next_state  = esr_pkg::ST_ACK_IN;
          end else begin
            next_bit_cnt = bit_cnt + 1'b1;
            next_shreg   = {shreg[6:0], 1'b0};
            next_sda_oe  = !shreg[6];
          end
        end
      end
      esr_pkg::ST_ACK_IN: begin
        if (scl_rise) begin
          next_ack_seen = !sda_s;
        end else if (scl_fall) begin
          if (ack_seen) begin
            tx_load = 1'b1;
          end else begin
            next_state = esr_pkg::ST_IGNORE;
          end
        end
      end
    endcase
    if (tx_load) begin
      next_shreg    = fifo_valid ? fifo_data : esr_pkg::FILL_BYTE;
      next_sda_oe   = fifo_valid ? !fifo_data[7] : 1'b0;
      next_addr_cnt = addr_cnt + 1'b1;
      next_bit_cnt  = esr_pkg::BIT_RST;
      next_state    = esr_pkg::ST_TX;
    end
    if (start_det) begin
      next_state     = esr_pkg::ST_DEV;
      next_bit_cnt   = esr_pkg::BIT_RST;
      next_byte_full = 1'b0;
      next_sda_oe    = 1'b0;
    end else if (stop_det) begin
      next_state  = esr_pkg::ST_IDLE;
      next_sda_oe = 1'b0;
    end
  end

  assign pop = tx_load && fifo_valid;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state     <= esr_pkg::ST_IDLE;
      after     <= esr_pkg::AF_DONE;
      bit_cnt   <= esr_pkg::BIT_RST;
      shreg     <= esr_pkg::BYTE_RST;
      addr_hi   <= esr_pkg::BYTE_RST;
      byte_full <= 1'b0;
      ack_seen  <= 1'b0;
      sda_oe    <= 1'b0;
      sda_o     <= 1'b0;
      addr_cnt  <= ADDR_W'(esr_pkg::ADDR_RST);
    end else begin
      state     <= next_state;
      after     <= next_after;
      bit_cnt   <= next_bit_cnt;
      shreg     <= next_shreg;
      addr_hi   <= next_addr_hi;
      byte_full <= next_byte_full;
      ack_seen  <= next_ack_seen;
      sda_oe    <= next_sda_oe;
      sda_o     <= 1'b0;
      addr_cnt  <= next_addr_cnt;
    end
  end

  // ****************************************
  // Array prefetch
  // ****************************************
  logic [ADDR_W-1:0]       fetch_ptr;
  logic [ADDR_W-1:0]       next_fetch_ptr;
  logic                    pend;
  logic                    next_pend;
  logic                    discard;
  logic                    next_discard;
  esr_pkg::esr_rd_req_type next_rd_req;

  assign push = rd_rsp.valid && !discard && !flush;

  always_comb begin
    next_fetch_ptr  = fetch_ptr;
    next_pend       = pend;
    next_discard    = discard;
    next_rd_req     = rd_req;
    next_rd_req.en  = 1'b0;
    if (rd_rsp.valid) begin
      next_pend    = 1'b0;
      next_discard = 1'b0;
    end
    if (flush) begin
      next_fetch_ptr = next_addr_cnt;
      next_discard   = pend && !rd_rsp.valid;
      next_pend      = 1'b0;
    end else if (!pend && !discard && fifo_in_ready) begin
      // Wraps with the counter width
      next_rd_req.en   = 1'b1;
      next_rd_req.addr = 16'(fetch_ptr);
      next_fetch_ptr   = fetch_ptr + 1'b1;
      next_pend        = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fetch_ptr <= ADDR_W'(esr_pkg::ADDR_RST);
      pend      <= 1'b0;
      discard   <= 1'b0;
      rd_req    <= '0;
    end else begin
      fetch_ptr <= next_fetch_ptr;
      pend      <= next_pend;
      discard   <= next_discard;
      rd_req    <= next_rd_req;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_STOP_RELEASE: assert property (@(posedge clk_sys) disable iff (rst)
    stop_det |=> (!sda_oe && state == esr_pkg::ST_IDLE))
    else $error("sda still driven after stop");
  AST_NACK_ENDS: assert property (@(posedge clk_sys) disable iff (rst)
    (state == esr_pkg::ST_ACK_IN && scl_fall && !ack_seen && !start_det && !stop_det) |=>
      (state == esr_pkg::ST_IGNORE && !sda_oe))
    else $error("read continued without acknowledge");
  AST_ACK_NEXT: assert property (@(posedge clk_sys) disable iff (rst)
    (state == esr_pkg::ST_ACK_IN && scl_fall && ack_seen && !start_det && !stop_det) |=>
      (state == esr_pkg::ST_TX && bit_cnt == 3'h0))
    else $error("no next byte after acknowledge");
  AST_ADDR_STEP: assert property (@(posedge clk_sys) disable iff (rst)
    tx_load |=> (addr_cnt == ADDR_W'($past(addr_cnt) + 1'b1)))
    else $error("counter did not step after byte");
  AST_ADDR_WRAP: assert property (@(posedge clk_sys) disable iff (rst)
    (tx_load && (&addr_cnt)) |=> (addr_cnt == '0))
    else $error("counter did not wrap to zero");
  AST_NO_MATCH: assert property (@(posedge clk_sys) disable iff (rst)
    (state == esr_pkg::ST_DEV && scl_fall && byte_full && !start_det && !stop_det &&
     (shreg[7:4] != esr_pkg::DEV_TYPE || shreg[3:2] != sync2[3:2])) |=> (state == esr_pkg::ST_IGNORE && !sda_oe))
    else $error("foreign address answered");
  AST_READ_DIR: assert property (@(posedge clk_sys) disable iff (rst)
    (state == esr_pkg::ST_ACK_OUT && after == esr_pkg::AF_READ && scl_fall && !start_det && !stop_det) |=>
      (state == esr_pkg::ST_TX))
    else $error("read bit did not start transmit");
  AST_ACK_SLOT: assert property (@(posedge clk_sys) disable iff (rst)
    (state == esr_pkg::ST_ACK_IN) |-> !sda_oe)
    else $error("sda driven in acknowledge slot");
  AST_ACK_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    (state == esr_pkg::ST_ACK_OUT && !scl_fall) |=> (sda_oe || $past(start_det) || $past(stop_det)))
    else $error("acknowledge released early");

endmodule
`default_nettype wire

/* File: tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic        rnd;
    logic [14:0] addr;
    logic [7:0]  n;
  } esr_tb_row_type;

  logic                    clk_sys;
  logic                    rst;
  logic                    m_scl;
  logic                    m_oe;
  logic                    sda_o;
  logic                    sda_oe;
  logic                    wire_sda;
  esr_pkg::esr_line_type   line_in;
  esr_pkg::esr_rd_req_type rd_req;
  esr_pkg::esr_rd_rsp_type rd_rsp;
  logic [1:0]              straps;
  logic                    req_q;
  logic [14:0]             addr_q;
  logic [14:0]             cur;
  logic [8:0]              rx;
  int                      num_errors;
  int                      checks_done;
  esr_tb_row_type          rows [5] = '{'{1'h1, 15'h0010, 8'h01}, '{1'h0, 15'h0000, 8'h02},
                                        '{1'h1, 15'h7FFE, 8'h04}, '{1'h0, 15'h0000, 8'h01},
                                        '{1'h1, 15'h1234, 8'h14}};

  // ****************************************
  // Clock, wire and array model
  // ****************************************
  initial clk_sys = 1'h0;
  always #50 clk_sys = ~clk_sys;

  assign wire_sda = ~(sda_oe | m_oe);
  assign line_in  = {m_scl, wire_sda};

  function automatic logic [7:0] mem_byte(input logic [14:0] a);
    return a[7:0] ^ {1'h0, a[14:8]};
  endfunction

  always @(posedge clk_sys) begin
    req_q = rd_req.en;
    addr_q = rd_req.addr[14:0];
    #1;
    rd_rsp.valid = req_q;
    rd_rsp.data = mem_byte(addr_q);
  end

  esr_seq_read #(.ADDR_W(15), .FIFO_DEPTH(16)) uut (
    .clk_sys          (clk_sys),
    .rst              (rst),
    .addr_select_low  (straps[0]),
    .addr_select_high (straps[1]),
    .line_in          (line_in),
    .sda_o            (sda_o),
    .sda_oe           (sda_oe),
    .rd_req           (rd_req),
    .rd_rsp           (rd_rsp)
  );

  esr_master_model u_master (
    .clk_sys (clk_sys),
    .scl     (m_scl),
    .m_oe    (m_oe),
    .sda     (wire_sda)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic address(input logic [6:0] sel, input logic rw, input logic nack);
    u_master.start_cond();
    u_master.xfer({sel, rw, 1'h1}, rx);
    chk1(rx[0], nack);
  endtask

  task automatic random_addr(input logic [14:0] a);
    address({esr_pkg::DEV_TYPE, 3'h4}, 1'h0, 1'h0);
    u_master.xfer({1'h0, a[14:8], 1'h1}, rx);
    chk1(rx[0], 1'h0);
    u_master.xfer({a[7:0], 1'h1}, rx);
    chk1(rx[0], 1'h0);
    address({esr_pkg::DEV_TYPE, 3'h4}, 1'h1, 1'h0);
    cur = a;
  endtask

  task automatic read_n(input int n);
    for (int i = 0; i < n; i++) begin
      u_master.xfer({8'hFF, i == n - 1}, rx);
      chk8(rx[8:1], mem_byte(cur));
      cur = cur + 15'h0001;
    end
    chk1(rx[0], 1'h1);
    u_master.stop_cond();
    chk1(sda_oe, 1'h0);
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst = 1'h1;
    straps = 2'h2;
    rd_rsp = '0;
    num_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge clk_sys);
    #1;
    chk1(sda_oe, 1'h0);
    chk8(rd_req.addr[7:0], 8'h00);
    rst = 1'h0;
    cur = 15'h0000;
    u_master.tick(10);
    foreach (rows[i]) begin
      if (rows[i].rnd) begin
        random_addr(rows[i].addr);
      end else begin
        address({esr_pkg::DEV_TYPE, 3'h4}, 1'h1, 1'h0);
      end
      read_n(int'(rows[i].n));
      $display("Row %0d done", i);
    end
    // Wrong strap bits, then wrong device type, then a read continues
    address({esr_pkg::DEV_TYPE, 3'h2}, 1'h1, 1'h1);
    u_master.stop_cond();
    address({4'hB, 3'h4}, 1'h1, 1'h1);
    u_master.stop_cond();
    chk1(sda_oe, 1'h0);
    address({esr_pkg::DEV_TYPE, 3'h4}, 1'h1, 1'h0);
    read_n(2);
    $display("Address filter done");
    // Other strap setting: the old select is refused, the new one answered
    straps = 2'h1;
    u_master.tick(4);
    address({esr_pkg::DEV_TYPE, 3'h4}, 1'h1, 1'h1);
    u_master.stop_cond();
    address({esr_pkg::DEV_TYPE, 3'h2}, 1'h1, 1'h0);
    read_n(2);
    straps = 2'h2;
    u_master.tick(4);
    $display("Strap change done");
    // Write data after the word address is refused; the counter keeps the address
    address({esr_pkg::DEV_TYPE, 3'h4}, 1'h0, 1'h0);
    u_master.xfer({8'h05, 1'h1}, rx);
    chk1(rx[0], 1'h0);
    u_master.xfer({8'h55, 1'h1}, rx);
    chk1(rx[0], 1'h0);
    u_master.xfer({8'hA5, 1'h1}, rx);
    chk1(rx[0], 1'h1);
    u_master.stop_cond();
    cur = 15'h0555;
    address({esr_pkg::DEV_TYPE, 3'h4}, 1'h1, 1'h0);
    read_n(2);
    $display("Write refusal done");
    // Reset in mid-read, then the counter restarts at zero
    address({esr_pkg::DEV_TYPE, 3'h4}, 1'h1, 1'h0);
    u_master.xfer({8'hFF, 1'h0}, rx);
    rst = 1'h1;
    u_master.tick(2);
    rst = 1'h0;
    chk1(sda_oe, 1'h0);
    u_master.stop_cond();
    u_master.tick(10);
    cur = 15'h0000;
    address({esr_pkg::DEV_TYPE, 3'h4}, 1'h1, 1'h0);
    read_n(3);
    chk1(sda_o, 1'h0);
    $display("Reset in read done");
    report_and_stop();
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    num_errors++;
    $display("Watchdog expired");
    report_and_stop();
  end
endmodule
`default_nettype wire
